// *** src/adcpr_host.sv ***
// Purpose: host end: starts conversions, reads two bytes, streams words out
// Assumes: converter end on the same clock; busy_n and data pass two flip-flops
// Notes: reads only after busy rises, so reads never overlap a conversion
`timescale 1ns/1ps
`default_nettype none
module adcpr_host import adcpr_pkg::*; #(
  parameter int PULSE_CYCLES = START_CYC + 2,
  // select-to-data path is three converter flops plus two host flops, so six cycles at least
  parameter int SETTLE_CYCLES = 6
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  adcpr_if.host link,
  input wire logic start_in,
  output logic start_ready_out,
  output logic word_valid_out,
  input wire logic word_ready_in,
  output logic [RES_W-1:0] word_out
);
  initial begin
    if (PULSE_CYCLES < START_CYC + 2 || PULSE_CYCLES > 255 || SETTLE_CYCLES < 6 || SETTLE_CYCLES > 255)
      $error("adcpr_host: bad pulse or settle count");
  end
  typedef struct packed {
    logic [1:0] bsync;
    logic [RES_W-1:0] d1;
    logic [RES_W-1:0] d2;
    logic busy_prev;
    adcpr_hstate_t st;
    logic [7:0] cnt;
    logic cs_n;
    logic rd_conv;
    logic byte_sel;
    logic [RES_W-1:0] word;
  } adcpr_host_t;
  adcpr_host_t s_q, s_d;
  logic busy_rise, buf_ready;

  always_comb begin
    s_d = s_q;
    s_d.bsync = {s_q.bsync[0], link.busy_n};
    s_d.d1 = link.result_bits_in;
    s_d.d2 = s_q.d1;
    s_d.busy_prev = s_q.bsync[1];
    busy_rise = s_q.bsync[1] && !s_q.busy_prev;
    case (s_q.st)
      ADCPR_H_IDLE: begin
        if (start_in && buf_ready) begin
          s_d.cs_n = 1'b0;
          s_d.rd_conv = 1'b0;
          s_d.cnt = '0;
          s_d.st = ADCPR_H_CONV;
        end
      end
      ADCPR_H_CONV: begin
        s_d.cnt = s_q.cnt + 8'd1;
        if (s_q.cnt + 8'd1 >= 8'(PULSE_CYCLES)) begin
          s_d.cs_n = 1'b1;
          s_d.rd_conv = 1'b1;
          s_d.st = ADCPR_H_WAIT;
        end
      end
      ADCPR_H_WAIT: begin
        if (busy_rise) begin
          s_d.cs_n = 1'b0;
          s_d.byte_sel = 1'b0;
          s_d.cnt = '0;
          s_d.st = ADCPR_H_READ;
        end
      end
      ADCPR_H_READ: begin
        s_d.cnt = s_q.cnt + 8'd1;
        if (s_q.cnt + 8'd1 >= 8'(SETTLE_CYCLES)) begin
          s_d.cnt = '0;
          if (!s_q.byte_sel) begin
            s_d.word[RES_W-1:BYTE_W] = s_q.d2[RES_W-1:BYTE_W];
            s_d.byte_sel = 1'b1;
          end else begin
            s_d.word[BYTE_W-1:0] = s_q.d2[BYTE_W-1:0];
            s_d.cs_n = 1'b1;
            s_d.byte_sel = 1'b0;
            s_d.st = ADCPR_H_PUSH;
          end
        end
      end
      ADCPR_H_PUSH: begin
        if (buf_ready) begin
          s_d.st = ADCPR_H_IDLE;
        end
      end
      default: begin
        s_d.st = ADCPR_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
      s_q.bsync <= 2'b11;
      s_q.busy_prev <= 1'b1;
      s_q.cs_n <= 1'b1;
      s_q.rd_conv <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.cs_n = s_q.cs_n;
  assign link.rd_conv = s_q.rd_conv;
  assign link.byte_sel = s_q.byte_sel;
  assign start_ready_out = (s_q.st == ADCPR_H_IDLE) && buf_ready;

  adcpr_buf2 #(
    .W(RES_W)
  ) u_buf (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(s_q.st == ADCPR_H_PUSH),
    .in_ready_out(buf_ready),
    .in_data_in(s_q.word),
    .out_valid_out(word_valid_out),
    .out_ready_in(word_ready_in),
    .out_data_out(word_out)
  );
endmodule
`default_nettype wire

// *** src/adcpr_pkg.sv ***
// Purpose: shared constants and types for the parallel converter readout link
// Assumes: 125 MHz clock, 8 ns period
// Notes: times are kept in their printed unit, cycle counts derive from them
package adcpr_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int RES_W = 16;
  localparam int BYTE_W = 8;
  // timing figures as printed
  localparam int T_START_NS = 40;
  localparam int T_PREV_VALID_NS = 5000;
  localparam int T_DATA_VALID_NS = 8000;
  localparam int T_BUSY_AFTER_DATA_NS = 50;
  // least times round up, longest times round down
  localparam int START_CYC = (T_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PREV_VALID_CYC = (T_PREV_VALID_NS * 1000) / CLK_PERIOD_PS;
  localparam int CONV_CYC = (T_DATA_VALID_NS * 1000) / CLK_PERIOD_PS;
  localparam int BUSY_GAP_CYC = (T_BUSY_AFTER_DATA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [RES_W-1:0] CODE_ZERO = 16'h0000;
  localparam logic [RES_W-1:0] CODE_MID = 16'h8000;
  localparam logic [RES_W-1:0] CODE_BELOW_MID = 16'h7FFF;
  localparam logic [RES_W-1:0] CODE_FULL = 16'hFFFF;
  localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
  typedef enum logic [1:0] {
    ADCPR_IDLE = 2'b00,
    ADCPR_CONV = 2'b01,
    ADCPR_GAP = 2'b10
  } adcpr_state_t;
  typedef enum logic [2:0] {
    ADCPR_H_IDLE = 3'b000,
    ADCPR_H_CONV = 3'b001,
    ADCPR_H_WAIT = 3'b010,
    ADCPR_H_READ = 3'b011,
    ADCPR_H_PUSH = 3'b100
  } adcpr_hstate_t;
endpackage

// *** src/adcpr_if.sv ***
// Purpose: parallel result port link between converter and host
// Assumes: one clock domain; data lines resolved by the bench from enables
// Notes: result_bits output enable is active low (low while driving)
`timescale 1ns/1ps
`default_nettype none
interface adcpr_if;
  logic cs_n;
  logic rd_conv;
  logic byte_sel;
  logic busy_n;
  logic [15:0] result_bits_out;
  logic result_bits_oe_n;
  logic [15:0] result_bits_in;
  modport dev (
    input cs_n, rd_conv, byte_sel,
    output busy_n, result_bits_out, result_bits_oe_n
  );
  modport host (
    output cs_n, rd_conv, byte_sel,
    input busy_n, result_bits_in
  );
endinterface
`default_nettype wire

// *** src/adcpr_buf2.sv ***
// Purpose: two-entry valid/ready buffer in the host's result path
// Assumes: single clock
// Notes: full and empty are exact; depth fixed at two entries
`timescale 1ns/1ps
`default_nettype none
module adcpr_buf2 import adcpr_pkg::*; #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  initial begin
    if (W < 1) $error("adcpr_buf2: width must be positive");
  end
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } adcpr_buf_t;
  adcpr_buf_t s_q, s_d;
  logic push, pop;
  always_comb begin
    in_ready_out = (s_q.cnt != 2'd2);
    out_valid_out = (s_q.cnt != 2'd0);
    out_data_out = s_q.mem[s_q.rd];
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data_in;
      s_d.wr = ~s_q.wr;
    end
    if (pop) begin
      s_d.rd = ~s_q.rd;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// *** src/adcpr_dev.sv ***
// Functional notes
// - drive result lines only when read selected
// - straight binary, word or two bytes
// - byte select swaps byte of same result (code puts the low byte on both lanes)
// - zero 0000, mid 8000, full FFFF
// - update output register before busy rises
// - host latches on busy rising edge
// - previous result valid 5 us after start
// - host avoids reads 5 us until busy
// - host should avoid reads during conversion
// - cs low: read/convert alone controls both
// - new result valid within 8 us
// - busy rises at least 50 ns after data
// - both low 40 ns starts, busy low
// - start requests ignored while busy low
// - host releases selects before busy rises
//
// Purpose: converter end of the parallel readout link
// Assumes: sample_in is the analog input already quantised to an unsigned code
// Notes: control pins are synchronised through two flip-flops before use
`timescale 1ns/1ps
`default_nettype none
module adcpr_dev import adcpr_pkg::*; #(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int START_CYCLES = START_CYC,
  parameter int GAP_CYCLES = BUSY_GAP_CYC
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  adcpr_if.dev link,
  input wire logic [RES_W-1:0] sample_in,
  output logic conv_active_out
);
  initial begin
    if (CONV_CYCLES <= PREV_VALID_CYC || CONV_CYCLES > 1023) $error("adcpr_dev: bad conversion length");
    if (START_CYCLES < 1 || START_CYCLES > 255 || GAP_CYCLES < 1 || GAP_CYCLES > 255)
      $error("adcpr_dev: bad start or gap count");
  end
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    adcpr_state_t st;
    logic [9:0] cnt;
    logic [7:0] low_cnt;
    logic [RES_W-1:0] held;
    logic [RES_W-1:0] result;
    logic busy_n;
    logic [RES_W-1:0] dout;
    logic oe_n;
  } adcpr_dev_t;
  adcpr_dev_t s_q, s_d;
  logic cs_n_s, rdc_s, byte_s, both_low, read_on;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = {link.cs_n, link.rd_conv, link.byte_sel};
    s_d.sync2 = s_q.sync1;
    cs_n_s = s_q.sync2[2];
    rdc_s = s_q.sync2[1];
    byte_s = s_q.sync2[0];
    both_low = !cs_n_s && !rdc_s;
    read_on = !cs_n_s && rdc_s;
    // level-triggered start qualifier counts low time of the or'd selects
    if (both_low) begin
      if (s_q.low_cnt != 8'hFF) begin
        s_d.low_cnt = s_q.low_cnt + 8'd1;
      end
    end else begin
      s_d.low_cnt = '0;
    end
    case (s_q.st)
      ADCPR_IDLE: begin
        // held selects do not restart after busy rises: low_cnt saturates at FF during conversion, and at FF the 8-bit +1 wraps to 0
        if (both_low && (s_q.low_cnt + 8'd1 >= 8'(START_CYCLES))) begin
          s_d.st = ADCPR_CONV;
          s_d.busy_n = 1'b0;
          s_d.held = sample_in;
          s_d.cnt = '0;
        end
      end
      ADCPR_CONV: begin
        // selects are not looked at here: starts are ignored
        s_d.cnt = s_q.cnt + 10'd1;
        if (s_q.cnt + 10'd1 >= 10'(CONV_CYCLES)) begin
          s_d.result = s_q.held;
          s_d.st = ADCPR_GAP;
          s_d.cnt = '0;
        end
      end
      ADCPR_GAP: begin
        s_d.cnt = s_q.cnt + 10'd1;
        if (s_q.cnt + 10'd1 >= 10'(GAP_CYCLES)) begin
          s_d.busy_n = 1'b1;
          s_d.st = ADCPR_IDLE;
        end
      end
      default: begin
        s_d.st = ADCPR_IDLE;
        s_d.busy_n = 1'b1;
      end
    endcase
    // previous result stays readable: result register only changes at end of conversion
    s_d.oe_n = !read_on;
    if (byte_s) begin
      s_d.dout = {s_q.result[BYTE_W-1:0], s_q.result[BYTE_W-1:0]};
    end else begin
      s_d.dout = s_q.result;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
      s_q.sync1 <= 3'b110;
      s_q.sync2 <= 3'b110;
      s_q.busy_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.result <= RESULT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.busy_n = s_q.busy_n;
  assign link.result_bits_out = s_q.dout;
  assign link.result_bits_oe_n = s_q.oe_n;
  assign conv_active_out = !s_q.busy_n;
endmodule
`default_nettype wire

// *** bench/adcpr_link_assertions.sv ***
// Purpose: wire-level checks on the converter/host link
// Assumes: one clock, data and enable follow synced pins
// Notes: latency slack of one cycle kept on enable checks
`timescale 1ns/1ps
`default_nettype none
module adcpr_link_assertions import adcpr_pkg::*; #(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int START_CYCLES = START_CYC,
  parameter int GAP_CYCLES = BUSY_GAP_CYC
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic cs_n,
  input wire logic rd_conv,
  input wire logic byte_sel,
  input wire logic busy_n,
  input wire logic [15:0] result_bits_out,
  input wire logic result_bits_oe_n
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [10:0] low_cnt_q;
  logic [3:0] sel_cnt_q;
  // -------------------------
  // helper counters
  // -------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_cnt_q <= 11'h000;
      sel_cnt_q <= 4'h0;
    end else begin
      low_cnt_q <= busy_n ? 11'h000 : low_cnt_q + 11'h001;
      sel_cnt_q <= (cs_n || rd_conv) ? 4'h0 : ((sel_cnt_q == 4'hF) ? sel_cnt_q : sel_cnt_q + 4'h1);
    end
  end
  property p_oe_src;
    !result_bits_oe_n |-> $past(!cs_n && rd_conv, 2) || $past(!cs_n && rd_conv, 3);
  endproperty
  property p_oe_on;
    (!cs_n && rd_conv) [*4] |-> !result_bits_oe_n;
  endproperty
  property p_oe_off;
    (cs_n || !rd_conv) [*4] |-> result_bits_oe_n;
  endproperty
  property p_byte_dup;
    !result_bits_oe_n && $past(byte_sel, 2) && $past(byte_sel, 3) && $past(byte_sel, 4)
      |-> result_bits_out[15:8] == result_bits_out[7:0];
  endproperty
  property p_start_len;
    $fell(busy_n) |-> $past(sel_cnt_q) >= START_CYCLES;
  endproperty
  property p_busy_max;
    low_cnt_q <= CONV_CYCLES + GAP_CYCLES + 1;
  endproperty
  property p_busy_min;
    $rose(busy_n) |-> low_cnt_q >= CONV_CYCLES + GAP_CYCLES - 1;
  endproperty
  property p_release;
    $rose(busy_n) |-> cs_n || rd_conv;
  endproperty
  property p_no_read_conv;
    !busy_n |-> cs_n || !rd_conv;
  endproperty
  // old result must not move while busy is low until the conversion time is over
  property p_prev_hold;
    !busy_n && $past(!busy_n) && (low_cnt_q < CONV_CYCLES) && ($past(byte_sel, 3) == $past(byte_sel, 4))
      |-> $stable(result_bits_out);
  endproperty
  a_oe_src: assert property (p_oe_src) else $error("data driven without read select");
  a_oe_on: assert property (p_oe_on) else $error("data not driven on read select");
  a_oe_off: assert property (p_oe_off) else $error("data driven while deselected");
  a_byte_dup: assert property (p_byte_dup) else $error("low byte not on both lanes");
  a_start_len: assert property (p_start_len) else $error("start on short select pulse");
  a_busy_max: assert property (p_busy_max) else $error("busy low too long");
  a_busy_min: assert property (p_busy_min) else $error("busy rose too early");
  a_release: assert property (p_release) else $error("selects low at busy rise");
  a_no_read_conv: assert property (p_no_read_conv) else $error("read during conversion");
  a_prev_hold: assert property (p_prev_hold) else $error("previous result changed early");
  c_rise: cover property ($rose(busy_n));
  c_fall: cover property ($fell(busy_n));
  c_byte: cover property (!result_bits_oe_n && byte_sel);
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Purpose: runs conversions end to end and checks streamed words
// Assumes: converter time shortened to 700 cycles
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("Error at %0t: got %h want %h", $time, a, e); end end
module tb import adcpr_pkg::*;;
  localparam int CONV = 700;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic start_in = 1'b0;
  logic word_ready_in = 1'b0;
  logic [15:0] sample_in = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] word_out;
  logic start_ready_out, word_valid_out, conv_active_out;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] codes [5] = '{16'h0000, 16'h8000, 16'h7FFF, 16'hFFFF, 16'hA53C};
  adcpr_if i_adcpr_if ();
  // undriven lines must not look like stale data
  assign i_adcpr_if.result_bits_in = !i_adcpr_if.result_bits_oe_n ? i_adcpr_if.result_bits_out : ~last_q;
  always @(posedge clk_in) begin
    if (!i_adcpr_if.result_bits_oe_n) last_q <= i_adcpr_if.result_bits_out;
  end
  adcpr_dev #(.CONV_CYCLES(CONV)) i_adcpr_dev (.clk_in(clk_in), .nrst_in(nrst_in), .link(i_adcpr_if.dev),
    .sample_in(sample_in), .conv_active_out(conv_active_out));
  adcpr_host i_adcpr_host (.clk_in(clk_in), .nrst_in(nrst_in), .link(i_adcpr_if.host), .start_in(start_in),
    .start_ready_out(start_ready_out), .word_valid_out(word_valid_out), .word_ready_in(word_ready_in),
    .word_out(word_out));
  adcpr_link_assertions #(.CONV_CYCLES(CONV)) i_adcpr_link_assertions (.clk_in(clk_in), .nrst_in(nrst_in),
    .cs_n(i_adcpr_if.cs_n), .rd_conv(i_adcpr_if.rd_conv), .byte_sel(i_adcpr_if.byte_sel),
    .busy_n(i_adcpr_if.busy_n), .result_bits_out(i_adcpr_if.result_bits_out),
    .result_bits_oe_n(i_adcpr_if.result_bits_oe_n));
  // -------------------------
  // clock, tasks, sequence
  // -------------------------
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic start_conv(input logic [15:0] s);
    @(posedge clk_in);
    sample_in <= s;
    start_in <= 1'b1;
    do @(negedge clk_in); while (start_ready_out !== 1'b1);
    @(posedge clk_in);
    start_in <= 1'b0;
  endtask
  task automatic pull(input logic [15:0] e);
    @(posedge clk_in);
    word_ready_in <= 1'b1;
    do @(negedge clk_in); while (word_valid_out !== 1'b1);
    `CHK(word_out, e)
    @(posedge clk_in);
    word_ready_in <= 1'b0;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    foreach (codes[i]) begin
      start_conv(codes[i]);
      pull(codes[i]); // both bytes of each code
    end
    start_conv(16'h1234);
    repeat (20) @(negedge clk_in);
    `CHK(conv_active_out, 1'b1) // conversion running
    `CHK(start_ready_out, 1'b0) // no start while busy
    repeat (CONV + 100) @(negedge clk_in);
    start_conv(16'h5678);
    repeat (CONV + 100) @(negedge clk_in);
    `CHK(start_ready_out, 1'b0) // buffer full with receiver stalled
    pull(16'h1234); // held result
    pull(16'h5678); // second result in order
    @(negedge clk_in);
    `CHK(word_valid_out, 1'b0)
    give_verdict();
  end
endmodule
`default_nettype wire
